/* src/msp_consts.vh */
// Purpose: Shared constants of the meter serial port
// Assumes: Included by bare name from the design file
// Notes:   Definitions only
`ifndef MSP_CONSTS_VH
`define MSP_CONSTS_VH
// Waveform sample width and byte width
`define MSP_SAMPLE_W    24
`define MSP_BYTE_W      8
// Sample buffer depth and its address width; pointers carry one bit more
`define MSP_FIFO_DEPTH  32
`define MSP_FIFO_AW     5
// Bit counter reset value and end-of-byte count
`define MSP_CNT_RST     5'h00
`define MSP_RX_LAST     3'h7
// Rising edges that launch one sample, bits of one sample
`define MSP_TX_BITS     5'h18
// Highest waveform sample rate, samples per second
`define MSP_MAX_SPS     26000
// Own clock rate in hertz
`define MSP_CLK_HZ      25000000
// Least own-clock cycles between two samples at the highest rate
`define MSP_SAMPLE_CYC  (`MSP_CLK_HZ / `MSP_MAX_SPS)
`endif

/* src/msp_serial_port.v */
// Purpose: Slave serial port with waveform sample stream and request line
// Assumes: Host makes the serial clock; pins sampled on sys_clk_i
// Notes:   Serial clock must stay well below a quarter of sys_clk_i
`timescale 1ns/1ps
`include "msp_consts.vh"

// Sample buffer, first word first out
module msp_fifo #(
   parameter WIDTH = `MSP_SAMPLE_W,
   parameter DEPTH = `MSP_FIFO_DEPTH,
   parameter AW    = `MSP_FIFO_AW
) (
   input  wire             clk_i,      // Own clock
   input  wire             rst_n_i,    // Sync reset, active low
   input  wire [WIDTH-1:0] in_data_i,  // Word to store
   input  wire             in_valid_i, // Word offered
   output wire             in_ready_o, // Room left
   output wire [WIDTH-1:0] out_data_o, // Oldest word
   output wire             out_valid_o,// Word held
   input  wire             out_ready_i // Take oldest word
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];    // Word storage
   reg [AW:0]      wr_ptr;             // Write pointer, wrap bit on top
   reg [AW:0]      rd_ptr;             // Read pointer, wrap bit on top
   // One spare pointer bit tells full from empty
   wire full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   wire empty = (wr_ptr == rd_ptr);
   wire push  = in_valid_i & ~full;
   wire pop   = out_ready_i & ~empty;

   assign in_ready_o  = ~full;
   assign out_valid_o = ~empty;
   assign out_data_o  = mem[rd_ptr[AW-1:0]];

   // Storage write, no reset needed
   always @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end

   // Pointer update
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule // msp_fifo

// Function
// - Transfers only while chip select low
// - Input bits captured on serial clock fall
// - Output bits launched on serial clock rise
// - Data output released unless sending samples
// - Host serial clock times every transfer
// - Request line only pulled low, never high
// - Maskable energy and sample interrupt sources
// - Sample request, 24 bits, MSB byte first
module msp_serial_port (
   input  wire                     sys_clk_i,       // Own clock, 25 MHz
   input  wire                     rst_n_i,         // Sync reset, active low
   input  wire                     cs_n_i,          // Chip select pin
   input  wire                     sclk_i,          // Serial clock pin
   input  wire                     din_i,           // Serial data in pin
   output wire                     dout_o,          // Serial data out
   output wire                     dout_oe_o,       // Drive enable of data out
   output wire                     irq_n_o,         // Request line level
   output wire                     irq_n_oe_o,      // Pull request line low
   input  wire [`MSP_SAMPLE_W-1:0] sample_i,        // New waveform sample
   input  wire                     sample_valid_i,  // Sample offered
   output wire                     sample_ready_o,  // Buffer has room
   input  wire                     sample_ready_mask_i, // Sample irq enable
   input  wire                     active_half_i,   // Active energy half
   input  wire                     active_mask_i,   // Its irq enable
   input  wire                     apparent_half_i, // Apparent energy half
   input  wire                     apparent_mask_i, // Its irq enable
   input  wire                     irq_clear_i,     // Clear energy flags
   output reg  [`MSP_BYTE_W-1:0]   rx_byte_o,       // Received byte
   output reg                      rx_valid_o,      // Received byte pulse
   output reg                      active_flag_o,   // Active flag pending
   output reg                      apparent_flag_o  // Apparent flag pending
);
   reg [2:0] sync1;                    // First stage, read only by sync2
   reg [2:0] sync2;                    // Second stage: din, cs, sclk
   reg       sclk_prev;                // Serial clock one cycle ago
   reg       cs_prev;                  // Chip select one cycle ago
   wire sclk_s = sync2[0];
   wire cs_n_s = sync2[1];
   wire din_s  = sync2[2];
   // Edges count only while selected
   wire sclk_fall = sclk_prev & ~sclk_s & ~cs_n_s;
   wire sclk_rise = ~sclk_prev & sclk_s & ~cs_n_s;
   wire cs_fall   = cs_prev & ~cs_n_s;

   reg [`MSP_BYTE_W-2:0]   rx_shift;   // Bits of byte being received
   reg [2:0]               rx_cnt;     // Bits received in this byte
   reg [`MSP_SAMPLE_W-1:0] tx_shift;   // Sample bits left to send
   reg [4:0]               tx_cnt;     // Bits launched so far
   reg                     tx_act;     // Sample being sent
   reg                     dout;       // Data out flip-flop

   wire [`MSP_SAMPLE_W-1:0] buf_data;  // Oldest buffered sample
   wire                     buf_valid; // A sample waits

   // Sample buffer; popped when host opens a frame
   // A frame with nothing buffered keeps data out released
   msp_fifo #(
      .WIDTH (`MSP_SAMPLE_W),
      .DEPTH (`MSP_FIFO_DEPTH),
      .AW    (`MSP_FIFO_AW)
   ) u_fifo (
      .clk_i       (sys_clk_i),
      .rst_n_i     (rst_n_i),
      .in_data_i   (sample_i),
      .in_valid_i  (sample_valid_i),
      .in_ready_o  (sample_ready_o),
      .out_data_o  (buf_data),
      .out_valid_o (buf_valid),
      .out_ready_i (cs_fall)
   );

   // Pin synchronisers and edge history
   // Reset values match idle pins, so no false edge follows reset
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         sync1     <= 3'h2;
         sync2     <= 3'h2;
         sclk_prev <= 1'b0;
         cs_prev   <= 1'b1;
      end else begin
         sync1     <= {din_i, cs_n_i, sclk_i};
         sync2     <= sync1;
         sclk_prev <= sync2[0];           // Serial clock sampled
         cs_prev   <= sync2[1];
      end
   end

   // Receive path, byte at a time
   // A cut byte leaves stale bits; the count restart hides them
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rx_shift   <= 7'h00;
         rx_cnt     <= 3'h0;
         rx_byte_o  <= 8'h00;
         rx_valid_o <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         if (cs_n_s) begin
            rx_cnt <= 3'h0;               // Drop partial byte
         end else if (sclk_fall) begin
            rx_shift <= {rx_shift[5:0], din_s}; // Capture on fall
            rx_cnt   <= rx_cnt + 3'h1;
            if (rx_cnt == `MSP_RX_LAST) begin
               rx_byte_o  <= {rx_shift, din_s};
               rx_valid_o <= 1'b1;
            end
         end
      end
   end

   // Transmit path, one 24-bit sample per frame
   // Rise 25 drops the drive even if the host keeps the frame open
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         tx_shift <= 24'h000000;
         tx_cnt   <= `MSP_CNT_RST;
         tx_act   <= 1'b0;
         dout     <= 1'b0;
      end else if (cs_n_s) begin
         tx_act <= 1'b0;                  // Frame ended, stop
         tx_cnt <= `MSP_CNT_RST;
      end else if (cs_fall) begin
         tx_shift <= buf_data;            // Whole sample, MSB first
         tx_act   <= buf_valid;
         tx_cnt   <= `MSP_CNT_RST;
         dout     <= 1'b0;
      end else if (sclk_rise && tx_act) begin
         if (tx_cnt == `MSP_TX_BITS) begin
            tx_act <= 1'b0;               // All three bytes sent
         end else begin
            dout     <= tx_shift[`MSP_SAMPLE_W-1]; // Launch on rise
            tx_shift <= {tx_shift[`MSP_SAMPLE_W-2:0], 1'b0};
            tx_cnt   <= tx_cnt + 5'h01;
         end
      end
   end

   // Drive data out only while a sample is sent
   assign dout_o    = dout;
   assign dout_oe_o = tx_act & ~cs_n_s;

   // Energy flags: set wins over clear
   // An event in the clearing cycle is kept, never lost
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         active_flag_o   <= 1'b0;
         apparent_flag_o <= 1'b0;
      end else begin
         active_flag_o   <= (active_half_i & active_mask_i) |
                            (active_flag_o & ~irq_clear_i);
         apparent_flag_o <= (apparent_half_i & apparent_mask_i) |
                            (apparent_flag_o & ~irq_clear_i);
      end
   end

   // Request: open drain, only ever pulls low
   // Sample source stays on while any sample waits
   assign irq_n_o    = 1'b0;
   assign irq_n_oe_o = active_flag_o | apparent_flag_o |
                       (sample_ready_mask_i & buf_valid);
endmodule // msp_serial_port

/* sim/msp_serial_port_props.sv */
// Purpose: Port checks of the serial port
// Assumes: Bound to msp_serial_port
// Notes:   Pins pass two sync stages
`timescale 1ns/1ps
module msp_props (
   input wire sys_clk_i, rst_n_i, cs_n_i, sclk_i, dout_o, dout_oe_o, irq_n_o,
   input wire irq_n_oe_o, sample_ready_o, sample_ready_mask_i, active_half_i,
   input wire active_mask_i, irq_clear_i, rx_valid_o, active_flag_o,
   input wire apparent_flag_o, apparent_half_i, apparent_mask_i
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Link clock rose, or fell, a few edges back
   sequence s_rise; $past(sclk_i, 2) && !$past(sclk_i, 6); endsequence
   sequence s_fall; !$past(sclk_i, 2) && $past(sclk_i, 6); endsequence
   chk_irq_low_only: assert property (irq_n_o == 1'b0)
      else $error("request high");
   chk_oe_needs_cs: assert property (cs_n_i [*3] |-> !dout_oe_o)
      else $error("driven unselected");
   chk_rx_needs_cs: assert property (cs_n_i [*4] |-> !rx_valid_o)
      else $error("byte unselected");
   chk_dout_on_rise: assert property (dout_oe_o && $past(dout_oe_o)
      && $changed(dout_o) |-> s_rise) else $error("out off rise");
   chk_rx_on_fall: assert property (rx_valid_o |-> s_fall)
      else $error("byte off fall");
   chk_flag_sets: assert property (active_half_i && active_mask_i
      |=> active_flag_o) else $error("flag not set");
   chk_flag_clears: assert property (irq_clear_i && !active_half_i
      |=> !active_flag_o) else $error("flag not cleared");
   chk_irq_source: assert property ((active_flag_o || apparent_flag_o
      || sample_ready_mask_i && !sample_ready_o) |-> irq_n_oe_o)
      else $error("request missing");
   chk_irq_quiet: assert property (!active_flag_o && !apparent_flag_o
      && !sample_ready_mask_i |-> !irq_n_oe_o) else $error("request unmasked");
   chk_mask_holds: assert property (apparent_half_i
      && !apparent_mask_i && !apparent_flag_o |=> !apparent_flag_o)
      else $error("masked event set flag");
endmodule // msp_props
bind msp_serial_port msp_props msp_props_i (.sys_clk_i(sys_clk_i),
   .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i), .dout_o(dout_o),
   .dout_oe_o(dout_oe_o), .irq_n_o(irq_n_o), .irq_n_oe_o(irq_n_oe_o),
   .sample_ready_o(sample_ready_o),
   .sample_ready_mask_i(sample_ready_mask_i),
   .active_half_i(active_half_i), .active_mask_i(active_mask_i),
   .irq_clear_i(irq_clear_i), .rx_valid_o(rx_valid_o),
   .active_flag_o(active_flag_o), .apparent_flag_o(apparent_flag_o),
   .apparent_half_i(apparent_half_i), .apparent_mask_i(apparent_mask_i));

/* sim/msp_host.sv */
// Purpose: Host side of the serial link
// Assumes: Link clock idles low
// Notes:   Half link period is four own clocks
`timescale 1ns/1ps
module msp_host (
   input  wire clk_i,      // Own clock
   input  wire dout_i,     // Device data out
   input  wire dout_oe_i,  // Its drive enable
   output reg  cs_n_o = 1, // Select, active low
   output reg  sclk_o = 0, // Link clock, still between frames
   output reg  din_o = 0   // Data to device
);
   wire pin = dout_oe_i ? dout_i : ~dout_i; // Released line shows inverse
   // Frame of nb bits, both words MSB first
   task frame(input int nb, input [23:0] w, output [23:0] rd);
      cs_n_o = 0;
      for (int i = 0; i < nb; i++) begin
         repeat (2) @(negedge clk_i);
         din_o = w[23 - i];
         repeat (2) @(negedge clk_i);
         sclk_o = 1;
         repeat (4) @(negedge clk_i);
         rd = {rd[22:0], pin};
         sclk_o = 0;
      end
      repeat (4) @(negedge clk_i);
      cs_n_o = 1;
      din_o = ~din_o; // Idle data moves, must be ignored
   endtask
endmodule // msp_host

/* sim/msp_serial_port_tb.sv */
// Purpose: Self-checking bench of the serial port
// Assumes: Host model drives the link pins
// Notes:   Link period 320 ns
`timescale 1ns/1ps
module msp_serial_port_tb;
   reg         clk = 0, rst_n = 0, valid = 0, mask = 0, clr = 0;
   reg         a_half = 0, a_mask = 0, p_half = 0, p_mask = 0;
   reg  [23:0] smp = 24'h000000, w, rd, e;
   wire        cs_n, sclk, din, dout, oe, irq_oe, ready, rx_v, a_fl, p_fl;
   wire        irq_n;                            // Request pin level
   wire        irq_line = irq_oe ? irq_n : 1'b1; // Host pull-up
   reg         master_clock_pin = 0;             // System master clock
   int         n_mclk = 0, m0;                   // Master clock rises
   wire [7:0]  rx_b;
   int         n_errors = 0, n_checks = 0, cyc = 0;
   logic [7:0] rxq[$]; // Bytes taken by the device
   always #20 clk = ~clk;
   always #50 master_clock_pin = ~master_clock_pin; // 10 MHz
   always @(posedge master_clock_pin) n_mclk++;
   msp_host msp_host_i (.clk_i(clk), .dout_i(dout), .dout_oe_i(oe),
      .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
   msp_serial_port msp_serial_port_i (.sys_clk_i(clk), .rst_n_i(rst_n),
      .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din), .dout_o(dout),
      .dout_oe_o(oe), .irq_n_o(irq_n), .irq_n_oe_o(irq_oe), .sample_i(smp),
      .sample_valid_i(valid), .sample_ready_o(ready),
      .sample_ready_mask_i(mask), .active_half_i(a_half),
      .active_mask_i(a_mask), .apparent_half_i(p_half),
      .apparent_mask_i(p_mask), .irq_clear_i(clr), .rx_byte_o(rx_b),
      .rx_valid_o(rx_v), .active_flag_o(a_fl), .apparent_flag_o(p_fl));
   // Collect received bytes, cut a hang short
   always @(negedge clk) begin
      if (rx_v === 1'b1) rxq.push_back(rx_b);
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         $display("BAD t=%0t timeout", $time);
         print_verdict();
      end
   end
   task chk(input logic [23:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Fill past full with mask low, then drain, one frame cut short
   task t_stream;
      valid = 1;
      for (int k = 0; k < 33; k++) begin
         smp = {k[7:0], ~k[7:0], 8'hA5};
         @(negedge clk);
      end
      valid = 0;
      chk({22'h0, ready, irq_oe}, 24'h000000);
      mask = 1;
      @(negedge clk);
      chk({23'h0, irq_oe}, 24'h000001);
      chk({23'h0, irq_line}, 24'h000000);
      for (int k = 0; k < 32; k++) begin
         e = {k[7:0], ~k[7:0], 8'hA5};
         w = ~e;
         msp_host_i.frame(k == 1 ? 12 : 24, w, rd);
         repeat (2) @(negedge clk);
         if (k == 1) chk({12'h0, rd[11:0]}, {12'h0, e[23:12]});
         else chk(rd, e);
         chk(24'(rxq.size()), k == 1 ? 24'h1 : 24'h3);
         foreach (rxq[b])
            chk({16'h0, rxq[b]}, {16'h0, w[23-8*b -: 8]});
         rxq.delete();
      end
      chk({22'h0, ready, irq_oe}, 24'h000002);
      // Frame with nothing buffered: data out stays released
      w = 24'h5A0000;
      msp_host_i.frame(8, w, rd);
      repeat (2) @(negedge clk);
      chk({16'h0, rd[7:0]}, 24'h0000FF);
      chk(24'(rxq.size()), 24'h000001);
      chk({16'h0, rxq[0]}, 24'h00005A);
      rxq.delete();
      $display("t_stream done");
   endtask
   // Energy flags: masked, set, clear against set, clear
   task t_energy;
      m0 = n_mclk;
      a_mask = 1;
      a_half = 1;
      p_half = 1;
      @(negedge clk);
      a_half = 0;
      p_half = 0;
      @(negedge clk);
      chk({21'h0, a_fl, p_fl, irq_oe}, 24'h000005);
      clr = 1;
      @(negedge clk);
      p_mask = 1;
      p_half = 1;
      @(negedge clk);
      clr = 0;
      p_half = 0;
      @(negedge clk);
      chk({21'h0, a_fl, p_fl, irq_oe}, 24'h000003);
      chk(24'(n_mclk - m0), 24'h000002);
      clr = 1;
      @(negedge clk);
      clr = 0;
      @(negedge clk);
      chk({21'h0, a_fl, p_fl, irq_oe}, 24'h000000);
      chk({23'h0, irq_line}, 24'h000001);
      $display("t_energy done");
   endtask
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1;
      repeat (3) @(negedge clk);
      t_stream();
      mask = 0;
      t_energy();
      print_verdict();
   end
endmodule // msp_serial_port_tb
